// file: core/dps_pkg.sv
// Package of constants for the dual PLL synthesizer control block
package dps_pkg;

    // Serial word layout
    localparam int WORD_W = 20;
    localparam logic [1:0] GRP_CHAN_A = 2'b10;
    localparam logic [1:0] GRP_CHAN_B = 2'b01;
    localparam logic [1:0] GRP_REF = 2'b11;
    localparam logic [1:0] GRP_OPTION = 2'b00;

    // Channel divider word fields
    localparam int SWALLOW_W = 5;
    localparam int PROG_W = 12;
    localparam int SWALLOW_LSB = 0;
    localparam int PROG_LSB = 5;
    // Reference divider word field
    localparam int REFDIV_W = 12;
    localparam int REFDIV_LSB = 0;
    // Option word field positions
    localparam int OPT_TEST_POS = 0;
    localparam int OPT_POL_POS = 1;
    localparam int OPT_CUR_HI_POS = 2;
    localparam int OPT_CUR_LO_POS = 3;
    localparam int OPT_SBA_POS = 4;
    localparam int OPT_SBB_POS = 5;
    localparam int OPT_SBR_POS = 6;
    localparam int OPT_LDA_POS = 7;
    localparam int OPT_LDB_POS = 8;
    localparam int OPT_FILT_POS = 9;

    // Reset values of the latches
    localparam logic [SWALLOW_W-1:0] SWALLOW_RST = 5'h00;
    localparam logic [PROG_W-1:0] PROG_RST = 12'h020;
    localparam logic [REFDIV_W-1:0] REFDIV_RST = 12'h008;
    localparam logic [9:0] OPTION_RST = 10'h000;

    // Lock detect: window in oscillator edges and streak of good cycles
    localparam int LOCK_WIN = 2;
    localparam int LOCK_STREAK = 3;

    // AHB-Lite register byte offsets
    localparam logic [7:0] ADDR_CHAN_A = 8'h00;
    localparam logic [7:0] ADDR_CHAN_B = 8'h04;
    localparam logic [7:0] ADDR_REF = 8'h08;
    localparam logic [7:0] ADDR_OPTION = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;

endpackage

// file: core/dps_synth_ctrl.sv
// Dual PLL synthesizer digital control: serial link, latches, dividers, lock detect
`timescale 1ns/100ps
module dps_synth_ctrl
    import dps_pkg::*;
#(
    parameter int WORD_BITS = WORD_W,
    parameter int SWALLOW_AT = SWALLOW_LSB,
    parameter int PROG_AT = PROG_LSB,
    parameter int REFDIV_AT = REFDIV_LSB,
    parameter int TEST_AT = OPT_TEST_POS,
    parameter int POL_AT = OPT_POL_POS,
    parameter int CUR_HI_AT = OPT_CUR_HI_POS,
    parameter int CUR_LO_AT = OPT_CUR_LO_POS,
    parameter int SBA_AT = OPT_SBA_POS,
    parameter int SBB_AT = OPT_SBB_POS,
    parameter int SBR_AT = OPT_SBR_POS,
    parameter int LDA_AT = OPT_LDA_POS,
    parameter int LDB_AT = OPT_LDB_POS,
    parameter int FILT_AT = OPT_FILT_POS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic serial_shift_pin,
    input wire logic serial_data_pin,
    input wire logic strobe_pin,
    input wire logic ref_osc_input,
    input wire logic rf_in_a,
    input wire logic rf_in_b,
    output logic ref_pulse,
    output logic [1:0] chan_pulse,
    output logic [1:0] chan_running,
    output logic ref_running,
    output logic [3:0] pump_current_code,
    output logic current_select_hi,
    output logic current_select_lo,
    output logic pump_polarity_bit,
    output logic test_mode,
    output logic lock_out_pin_o,
    output logic lock_out_pin_oe_n,
    output logic filter_switch_o,
    output logic filter_switch_oe_n
);

    // Group code occupies the top two bits, so the word must hold every field below it
    if (WORD_BITS < PROG_AT + PROG_W + 2 || WORD_BITS < SWALLOW_AT + SWALLOW_W + 2 ||
        WORD_BITS < REFDIV_AT + REFDIV_W + 2 || WORD_BITS < FILT_AT + 3) begin : g_bad_word
        $error("dps_synth_ctrl: serial word too narrow for its fields");
    end
    // Two-flop synchronisers for all pins; only stage 2 is read
    logic [5:0] pin_in, sync1_reg, sync2_reg, prev_reg, pin_rise;
    assign pin_in = {rf_in_b, rf_in_a, ref_osc_input, strobe_pin, serial_data_pin,
                     serial_shift_pin};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
            prev_reg <= 6'h00;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    assign pin_rise = sync2_reg & ~prev_reg;
    // Serial shift register and latches
    logic [WORD_BITS-1:0] shift_reg, shift_next;
    logic [SWALLOW_W+PROG_W-1:0] div_a_reg, div_a_next, div_b_reg, div_b_next;
    logic [REFDIV_W-1:0] ref_reg, ref_next;
    logic [9:0] opt_reg, opt_next;
    logic [31:0] ctrl_reg, ctrl_next;
    logic [1:0] grp_code;
    logic link_en;
    logic [9:0] opt_word;
    assign link_en = ctrl_reg[0];
    // Second-last bit is the first printed digit of the group code
    assign grp_code = {shift_reg[WORD_BITS-2], shift_reg[WORD_BITS-1]};
    // Gather option fields from their parameterised positions
    assign opt_word = {shift_reg[FILT_AT], shift_reg[LDB_AT], shift_reg[LDA_AT],
                       shift_reg[SBR_AT], shift_reg[SBB_AT], shift_reg[SBA_AT],
                       shift_reg[CUR_LO_AT], shift_reg[CUR_HI_AT], shift_reg[POL_AT],
                       shift_reg[TEST_AT]};
    // Shift on clock rise; commit on strobe rise
    always_comb begin
        shift_next = shift_reg;
        div_a_next = div_a_reg;
        div_b_next = div_b_reg;
        ref_next = ref_reg;
        opt_next = opt_reg;
        if (link_en && pin_rise[0])
            shift_next = {sync2_reg[1], shift_reg[WORD_BITS-1:1]};
        if (link_en && pin_rise[2]) begin
            case (grp_code)
                GRP_CHAN_A: div_a_next = {shift_reg[PROG_AT +: PROG_W],
                                          shift_reg[SWALLOW_AT +: SWALLOW_W]};
                GRP_CHAN_B: div_b_next = {shift_reg[PROG_AT +: PROG_W],
                                          shift_reg[SWALLOW_AT +: SWALLOW_W]};
                GRP_REF: ref_next = shift_reg[REFDIV_AT +: REFDIV_W];
                GRP_OPTION: opt_next = opt_word;
                default: opt_next = opt_reg;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg <= '0;
            div_a_reg <= {PROG_RST, SWALLOW_RST};
            div_b_reg <= {PROG_RST, SWALLOW_RST};
            ref_reg <= REFDIV_RST;
            opt_reg <= OPTION_RST;
        end else begin
            shift_reg <= shift_next;
            div_a_reg <= div_a_next;
            div_b_reg <= div_b_next;
            ref_reg <= ref_next;
            opt_reg <= opt_next;
        end
    end
    // Decoded option fields
    logic sb_a, sb_b, sb_r;
    assign sb_a = opt_reg[4];
    assign sb_b = opt_reg[5];
    assign sb_r = opt_reg[6];
    assign ref_running = !(sb_a && sb_b && sb_r);
    // Reference divider: 12-bit count of oscillator edges, then halving
    logic [REFDIV_W-1:0] rcnt_reg, rcnt_next;
    logic half_reg, half_next;
    logic ref_tick;
    logic ref_pulse_reg, ref_pulse_next;
    always_comb begin
        rcnt_next = rcnt_reg;
        half_next = half_reg;
        ref_tick = 1'b0;
        ref_pulse_next = 1'b0;
        if (!ref_running) begin
            rcnt_next = '0;
            half_next = 1'b0;
        end else if (pin_rise[3]) begin
            if (rcnt_reg >= ref_reg - 12'h001) begin
                rcnt_next = '0;
                ref_tick = 1'b1;
            end else begin
                rcnt_next = rcnt_reg + 12'h001;
            end
        end
        if (ref_tick) begin
            half_next = ~half_reg;
            ref_pulse_next = half_reg;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rcnt_reg <= '0;
            half_reg <= 1'b0;
            ref_pulse_reg <= 1'b0;
        end else begin
            rcnt_reg <= rcnt_next;
            half_reg <= half_next;
            ref_pulse_reg <= ref_pulse_next;
        end
    end
    assign ref_pulse = ref_pulse_reg;
    // Per-channel divider and lock detector
    logic [1:0] chan_locked;
    logic [1:0] chan_sb;
    assign chan_sb = {sb_b, sb_a};
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            logic [SWALLOW_W+PROG_W-1:0] set_val;
            logic [17:0] ratio;
            logic [17:0] ccnt_reg, ccnt_next;
            logic cp_reg, cp_next;
            logic pend_r_reg, pend_r_next, pend_c_reg, pend_c_next;
            logic [2:0] gap_reg, gap_next, streak_reg, streak_next;
            logic cpulse;
            assign set_val = (ch == 0) ? div_a_reg : div_b_reg;
            // Ratio 2*(32N+A): prescaler 64/66 absorbed into one edge count
            assign ratio = {set_val[SWALLOW_W +: PROG_W], 1'b0, 5'h00}
                           + {12'h000, set_val[SWALLOW_W-1:0], 1'b0};
            assign cpulse = !chan_sb[ch] && pin_rise[4+ch] && (ccnt_reg >= ratio - 18'h00001);
            always_comb begin
                ccnt_next = ccnt_reg;
                cp_next = cpulse;
                pend_r_next = pend_r_reg;
                pend_c_next = pend_c_reg;
                gap_next = gap_reg;
                streak_next = streak_reg;
                if (chan_sb[ch]) begin
                    ccnt_next = '0;
                    pend_r_next = 1'b0;
                    pend_c_next = 1'b0;
                    gap_next = '0;
                    streak_next = '0;
                end else begin
                    if (cpulse)
                        ccnt_next = '0;
                    else if (pin_rise[4+ch])
                        ccnt_next = ccnt_reg + 18'h00001;
                    // Gap counted in oscillator edges while only one side has arrived
                    if ((pend_r_reg ^ pend_c_reg) && pin_rise[3] && gap_reg != 3'h7)
                        gap_next = gap_reg + 3'h1;
                    if ((pend_r_reg || ref_pulse_reg) && (pend_c_reg || cp_reg)) begin
                        pend_r_next = 1'b0;
                        pend_c_next = 1'b0;
                        gap_next = '0;
                        if (gap_reg < 3'(LOCK_WIN)) begin
                            if (streak_reg <= 3'(LOCK_STREAK))
                                streak_next = streak_reg + 3'h1;
                        end else begin
                            streak_next = '0;
                        end
                    end else begin
                        pend_r_next = pend_r_reg || ref_pulse_reg;
                        pend_c_next = pend_c_reg || cp_reg;
                    end
                end
            end
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    ccnt_reg <= '0;
                    cp_reg <= 1'b0;
                    pend_r_reg <= 1'b0;
                    pend_c_reg <= 1'b0;
                    gap_reg <= '0;
                    streak_reg <= '0;
                end else begin
                    ccnt_reg <= ccnt_next;
                    cp_reg <= cp_next;
                    pend_r_reg <= pend_r_next;
                    pend_c_reg <= pend_c_next;
                    gap_reg <= gap_next;
                    streak_reg <= streak_next;
                end
            end
            // More than three good cycles; standby reads as locked
            assign chan_locked[ch] = chan_sb[ch] || (streak_reg > 3'(LOCK_STREAK));
            assign chan_pulse[ch] = cp_reg;
            assign chan_running[ch] = !chan_sb[ch];
        end
    endgenerate
    // Lock pin select; standby channels already read as high
    logic lock_level;
    always_comb begin
        case ({opt_reg[7], opt_reg[8]})
            2'b00: lock_level = 1'b0;
            2'b01: lock_level = chan_locked[1];
            2'b10: lock_level = chan_locked[0];
            2'b11: lock_level = chan_locked[0] & chan_locked[1];
            default: lock_level = 1'b0;
        endcase
    end
    // Drain output: only low is driven, high is released
    assign lock_out_pin_o = 1'b0;
    assign lock_out_pin_oe_n = lock_level;
    assign filter_switch_o = 1'b0;
    assign filter_switch_oe_n = !opt_reg[9];
    // Charge pump controls; one-hot code 100/200/400/800 uA
    assign current_select_hi = opt_reg[2];
    assign current_select_lo = opt_reg[3];
    assign pump_current_code = 4'h1 << {opt_reg[2], opt_reg[3]};
    assign pump_polarity_bit = opt_reg[1];
    assign test_mode = opt_reg[0];
    // AHB-Lite slave, zero wait states, always OKAY
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] addr_reg, addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] rd_mux;
    logic take;
    assign take = hsel && hready && htrans[1];
    always_comb begin
        case (haddr[7:0])
            ADDR_CHAN_A: rd_mux = {15'h0000, div_a_reg};
            ADDR_CHAN_B: rd_mux = {15'h0000, div_b_reg};
            ADDR_REF: rd_mux = {20'h00000, ref_reg};
            ADDR_OPTION: rd_mux = {22'h000000, opt_reg};
            ADDR_STATUS: rd_mux = {26'h0000000, lock_level, ref_running,
                                   chan_running, chan_locked};
            ADDR_CTRL: rd_mux = ctrl_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    always_comb begin
        wr_pend_next = take && hwrite;
        addr_next = take ? haddr[7:0] : addr_reg;
        rdata_next = (take && !hwrite) ? rd_mux : rdata_reg;
        ctrl_next = ctrl_reg;
        // Only bit 0 is live: it gates the serial link
        if (wr_pend_reg && addr_reg == ADDR_CTRL)
            ctrl_next = {31'h0000_0000, hwdata[0]};
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
            ctrl_reg <= CTRL_RST;
        end else begin
            wr_pend_reg <= wr_pend_next;
            addr_reg <= addr_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
        end
    end
    assign hrdata = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule

// file: dv/dps_serial_host.sv
// Behavioural host driving the three-wire serial control link
`timescale 1ns/100ps
module dps_serial_host
    import dps_pkg::*;
(
    output logic serial_shift_pin,
    output logic serial_data_pin,
    output logic strobe_pin
);
    // Shift and strobe stand low between frames
    initial begin
        serial_shift_pin = 1'b0;
        serial_data_pin = 1'b0;
        strobe_pin = 1'b0;
    end
    // One frame at an 80 ns shift period, off phase with the system clock
    task automatic send_word(input logic [WORD_W-1:0] word);
        #3;
        for (int i = 0; i < WORD_W; i++) begin
            serial_data_pin = word[i]; // Lowest bit first, group code last
            #20;
            serial_shift_pin = 1'b1;
            #40;
            serial_shift_pin = 1'b0;
            #20;
        end
        serial_data_pin = ~word[WORD_W-1]; // No stale level once the frame ends
        strobe_pin = 1'b1; // Commit only after the last bit
        #80;
        strobe_pin = 1'b0;
        #80;
    endtask
endmodule

// file: dv/dps_synth_ctrl_bench.sv
// Self-checking bench for the dual PLL synthesizer control block
`timescale 1ns/100ps
module dps_synth_ctrl_bench
    import dps_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic shift_pin, data_pin, strobe, ref_osc_input, rf_in_a, rf_in_b;
    logic ref_pulse, ref_running, test_mode, cur_hi, cur_lo, polarity;
    logic lock_o, lock_oe_n, filt_o, filt_oe_n;
    logic [1:0] chan_pulse, chan_running;
    logic [3:0] pump_current_code;
    int tick, errors, compares;
    dps_synth_ctrl i_dps_synth_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .serial_shift_pin(shift_pin), .serial_data_pin(data_pin), .strobe_pin(strobe),
        .ref_osc_input(ref_osc_input), .rf_in_a(rf_in_a), .rf_in_b(rf_in_b),
        .ref_pulse(ref_pulse), .chan_pulse(chan_pulse), .chan_running(chan_running),
        .ref_running(ref_running), .pump_current_code(pump_current_code),
        .current_select_hi(cur_hi), .current_select_lo(cur_lo),
        .pump_polarity_bit(polarity), .test_mode(test_mode), .lock_out_pin_o(lock_o),
        .lock_out_pin_oe_n(lock_oe_n), .filter_switch_o(filt_o),
        .filter_switch_oe_n(filt_oe_n)
    );
    dps_serial_host i_dps_serial_host (
        .serial_shift_pin(shift_pin), .serial_data_pin(data_pin), .strobe_pin(strobe)
    );
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Oscillator and channel inputs come from a tick count, so edge spacing is exact
    always @(posedge hclk) begin
        tick <= tick + 1;
        ref_osc_input <= (tick % 6) < 3;
        rf_in_a <= (tick % 4) < 2;
        rf_in_b <= ((tick + 1) % 4) < 2;
    end
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bounded wait for hready; a hang ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                errors++;
                finish_test();
            end
            @(posedge hclk);
        end
    endtask
    // Single word transfer: address phase, then data phase, data taken at its edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h0000_0000, rd);
        check(what, exp, rd);
        check("hresp", 32'h0, hresp);
    endtask
    // Group code X sits in bit 18 and Y in bit 19, the last bit shifted
    task automatic send(input logic [1:0] g, input logic [17:0] p);
        i_dps_serial_host.send_word({g[0], g[1], p});
        repeat (2) @(posedge hclk);
    endtask
    // Option fields in order filt ldb lda sbr sbb sba cur_lo cur_hi pol; test stays 0
    task automatic send_opt(input logic [8:0] f);
        send(GRP_OPTION, {8'h00, f, 1'b0});
    endtask
    task automatic wait_pulse(input int which, output int at);
        int n;
        n = 0;
        @(posedge hclk);
        while ((which == 0 ? ref_pulse : chan_pulse[which - 1]) !== 1'b1) begin
            n++;
            if (n > 10000) begin
                errors++;
                finish_test();
            end
            @(posedge hclk);
        end
        at = tick;
    endtask
    task automatic gap_chk(input string what, input int which, input int exp);
        int t0, t1;
        wait_pulse(which, t0);
        wait_pulse(which, t0);
        wait_pulse(which, t1);
        check(what, exp, t1 - t0);
    endtask
    task automatic t_reset();
        logic [31:0] rd;
        rd_chk("chan_a", ADDR_CHAN_A, 32'h0000_0400);
        rd_chk("refdiv", ADDR_REF, 32'h0000_0008);
        rd_chk("ctrl", ADDR_CTRL, CTRL_RST);
        ahb(1'b1, ADDR_REF, 32'h0000_0FFF, rd);
        rd_chk("ref_ro", ADDR_REF, 32'h0000_0008);
        rd_chk("unmapped", 8'h40, 32'h0000_0000);
        check("pump", 32'h1, pump_current_code);
        check("lock_low", 32'h0, lock_oe_n);
        $display("Done: reset and bus");
    endtask
    // Independent channel words, asymmetric patterns catch bit order, then ratios
    task automatic t_dividers();
        send(GRP_CHAN_A, 18'h00401);
        send(GRP_CHAN_B, 18'h00435);
        send(GRP_REF, 18'h00009);
        rd_chk("chan_a", ADDR_CHAN_A, 32'h0000_0401);
        rd_chk("chan_b", ADDR_CHAN_B, 32'h0000_0435);
        rd_chk("refdiv", ADDR_REF, 32'h0000_0009);
        gap_chk("ref_ratio", 0, 18 * 6);
        gap_chk("chan_a_ratio", 1, 2050 * 4);
        gap_chk("chan_b_ratio", 2, 2154 * 4);
        $display("Done: dividers");
    endtask
    task automatic t_options();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            send_opt({c[1], 5'h00, c[0], c[1], c[0]});
            check("pump", 32'h1 << i, pump_current_code);
            check("cur_hi", c[1], cur_hi);
            check("cur_lo", c[0], cur_lo);
            check("polarity", c[0], polarity);
            check("filter", !c[1], filt_oe_n);
            check("test", 32'h0, test_mode);
        end
        $display("Done: options");
    endtask
    // Rows {sba, sbb, lda, ldb, released}; only rows not hanging on lock state
    task automatic t_locks();
        logic [4:0] rows [8] = '{5'h00, 5'h0B, 5'h15, 5'h1B, 5'h1D, 5'h1F, 5'h18, 5'h10};
        foreach (rows[i]) begin
            send_opt({1'b0, rows[i][1], rows[i][2], 1'b0, rows[i][3], rows[i][4], 3'h0});
            check("lock_pin", rows[i][0], lock_oe_n);
        end
        $display("Done: lock select");
    endtask
    task automatic t_standby();
        logic [8:0] opts [3] = '{9'h018, 9'h028, 9'h038};
        logic [2:0] exp [3] = '{3'b100, 3'b110, 3'b000};
        foreach (opts[i]) begin
            send_opt(opts[i]);
            check("running", exp[i], {ref_running, chan_running});
        end
        repeat (200) @(posedge hclk);
        rd_chk("status", ADDR_STATUS, 32'h0000_0003);
        $display("Done: standby");
    endtask
    // A disabled link ignores a strobe; the latch keeps its old word
    task automatic t_link_off();
        logic [31:0] rd;
        send_opt(9'h000);
        ahb(1'b1, ADDR_CTRL, 32'h0000_0000, rd);
        rd_chk("ctrl", ADDR_CTRL, 32'h0000_0000);
        send_opt(9'h100);
        check("filter", 32'h1, filt_oe_n);
        ahb(1'b1, ADDR_CTRL, 32'h0000_0001, rd);
        send_opt(9'h100);
        check("filter", 32'h0, filt_oe_n);
        $display("Done: link enable");
    endtask
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {errors, compares} = '0;
        hsize = 3'h2;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_dividers();
        t_options();
        t_locks();
        t_standby();
        t_link_off();
        finish_test();
    end
endmodule

// file: dv/dps_synth_ctrl_checker.sv
// Concurrent checks on the top ports of the synthesizer control block
`timescale 1ns/100ps
module dps_synth_ctrl_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic strobe_pin,
    input wire logic ref_pulse,
    input wire logic [1:0] chan_pulse,
    input wire logic [1:0] chan_running,
    input wire logic ref_running,
    input wire logic [3:0] pump_current_code,
    input wire logic current_select_hi,
    input wire logic current_select_lo,
    input wire logic pump_polarity_bit,
    input wire logic test_mode,
    input wire logic lock_out_pin_o,
    input wire logic filter_switch_o,
    input wire logic filter_switch_oe_n
);
    logic [3:0] age_reg;
    logic [3:0] age_next;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Cycles since strobe was high; option outputs may only move shortly after it
    always_comb begin
        age_next = age_reg;
        if (strobe_pin) begin
            age_next = 4'h0;
        end else if (age_reg != 4'hF) begin
            age_next = age_reg + 4'h1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            age_reg <= 4'hF;
        end else begin
            age_reg <= age_next;
        end
    end
    // Divider outputs: single pulses, far apart at every ratio the bench loads
    sequence s_ref_quiet;
        !ref_pulse [*8];
    endsequence
    sequence s_a_quiet;
        !chan_pulse[0] [*8];
    endsequence
    sequence s_b_quiet;
        !chan_pulse[1] [*8];
    endsequence
    a_pump_code_map: assert property (pump_current_code ==
        (4'h1 << {current_select_hi, current_select_lo})) else $error("pump code wrong");
    a_ref_stop_rule: assert property (!ref_running |-> chan_running == 2'b00)
        else $error("reference stopped with a channel active");
    a_drain_low_only: assert property (!lock_out_pin_o && !filter_switch_o)
        else $error("open-drain output driven high");
    a_ref_pulse_gap: assert property (ref_pulse |=> s_ref_quiet)
        else $error("reference pulses too close");
    a_chan_a_gap: assert property (chan_pulse[0] |=> s_a_quiet)
        else $error("channel A pulses too close");
    a_chan_b_gap: assert property (chan_pulse[1] |=> s_b_quiet)
        else $error("channel B pulses too close");
    a_ref_idle_quiet: assert property (!ref_running [*4] |-> !ref_pulse)
        else $error("reference pulse while stopped");
    a_chan_idle_quiet: assert property (!chan_running[0] [*4] |-> !chan_pulse[0])
        else $error("channel A pulse in standby");
    a_option_on_strobe: assert property ($changed({test_mode, pump_polarity_bit,
        current_select_hi, current_select_lo, chan_running, filter_switch_oe_n})
        |-> age_reg < 4'h8) else $error("option output moved without strobe");
endmodule
bind dps_synth_ctrl dps_synth_ctrl_checker i_dps_synth_ctrl_checker (
    .hclk(hclk), .hresetn(hresetn), .strobe_pin(strobe_pin), .ref_pulse(ref_pulse),
    .chan_pulse(chan_pulse), .chan_running(chan_running), .ref_running(ref_running),
    .pump_current_code(pump_current_code), .current_select_hi(current_select_hi),
    .current_select_lo(current_select_lo), .pump_polarity_bit(pump_polarity_bit),
    .test_mode(test_mode), .lock_out_pin_o(lock_out_pin_o),
    .filter_switch_o(filter_switch_o), .filter_switch_oe_n(filter_switch_oe_n)
);
